// *** rtl/scm_defs.vh ***
// Purpose: Constants for the system clock and operating mode controller
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses
`ifndef SCM_DEFS_VH
`define SCM_DEFS_VH

// Register byte offsets
`define SCM_OFF_SYS_CTRL   12'h000
`define SCM_OFF_FRC_CTRL   12'h004
`define SCM_OFF_FXT_CTRL   12'h008
`define SCM_OFF_SXT_CTRL   12'h00c
`define SCM_OFF_STATUS     12'h010

// Control register fields
`define SCM_SEL_MSB        7
`define SCM_SEL_LSB        5
`define SCM_FSRC_BIT       3
`define SCM_SSRC_BIT       2
`define SCM_FKEEP_BIT      1
`define SCM_SKEEP_BIT      0
`define SCM_SEL_SUB        3'h7

// Oscillator control register fields
`define SCM_OSC_EN_BIT     0
`define SCM_OSC_STB_BIT    1
`define SCM_OSC_MODE_BIT   2
`define SCM_FRC_FREQ_MSB   3
`define SCM_FRC_FREQ_LSB   2

// Reset values
`define SCM_SYS_CTRL_RST   8'h00
`define SCM_SEL_RST        3'h0
`define SCM_FRC_RST        3'h1
`define SCM_FXT_RST        2'h0
`define SCM_SXT_RST        2'h0

// Operating modes
`define SCM_MODE_RUN       3'h0
`define SCM_MODE_SLEEP     3'h2
`define SCM_MODE_IDLE_SLOW_ONLY     3'h3
`define SCM_MODE_IDLE_BOTH_OSC     3'h4
`define SCM_MODE_IDLE_FAST_ONLY     3'h5

// Fast clock divider
`define SCM_DIV_W          6
`define SCM_DIV_WRAP       6'h3f

`endif

// *** rtl/scm_clock_mode.v ***
// Purpose: System clock selection and operating mode control behind APB
// Assumes: Oscillators appear as one-cycle tick strobes synchronous to clk
// Notes:   Clocks leave the block as tick enables, never as gated clocks
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "scm_defs.vh"

module scm_clock_mode (
  // Clock, reset, enable
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        ce,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // CPU side
  input  wire        halt_req,
  input  wire        wake_req,
  input  wire        watchdog_function_en,
  output wire        cpu_run,
  output reg         watchdog_clear,
  // Oscillator ticks and stable flags
  input  wire        fast_rc_tick,
  input  wire        fast_crystal_tick,
  input  wire        slow_rc_tick,
  input  wire        slow_crystal_tick,
  input  wire        fast_rc_stable,
  input  wire        fast_crystal_stable,
  input  wire        slow_crystal_stable,
  // Oscillator run controls
  output wire        fast_rc_osc_run,
  output wire        fast_crystal_osc_run,
  output wire        slow_rc_osc_run,
  output wire        slow_crystal_osc_run,
  output wire [1:0]  fast_rc_freq,
  output wire        fast_crystal_mode,
  output wire        slow_crystal_speed_up,
  // Clock enables
  output reg         sys_clk_tick,
  output wire        fast_clk_tick,
  output wire        sub_clk_tick,
  output wire        slow_rc_clock_tick
);

  // Control register fields
  reg  [2:0] sys_clk_selector_q;
  reg        fast_source_select_q;
  reg        slow_source_select_q;
  reg        fast_keep_alive_q;
  reg        slow_keep_alive_q;
  // Oscillator control fields
  reg  [1:0] frc_freq_q;
  reg        frc_en_q;
  reg        fxt_mode_q;
  reg        fxt_en_q;
  reg        sxt_speed_q;
  reg        sxt_en_q;
  // Mode and clock path state
  reg  [2:0] mode_q;
  reg        active_sub_q;
  reg  [2:0] div_active_q;
  reg  [5:0] div_cnt_q;

  wire       running   = (mode_q == `SCM_MODE_RUN);
  wire       want_sub  = (sys_clk_selector_q == `SCM_SEL_SUB);
  wire       sub_ready = slow_source_select_q ? slow_crystal_stable : 1'b1;
  wire       fast_rdy  = fast_source_select_q ? fast_crystal_stable : fast_rc_stable;

  // APB decode: single-cycle answer, unmapped addresses flag an error
  wire       acc     = psel & penable;
  wire       hit_sys = (paddr == `SCM_OFF_SYS_CTRL);
  wire       hit_frc = (paddr == `SCM_OFF_FRC_CTRL);
  wire       hit_fxt = (paddr == `SCM_OFF_FXT_CTRL);
  wire       hit_sxt = (paddr == `SCM_OFF_SXT_CTRL);
  wire       hit_sts = (paddr == `SCM_OFF_STATUS);
  wire       mapped  = hit_sys | hit_frc | hit_fxt | hit_sxt | hit_sts;
  wire       wr      = acc & pwrite & ce;

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // Fast, sub and system clock demand per mode
  reg fast_on;
  reg sub_on;
  reg sys_on;
  always @* begin
    case (mode_q)
      `SCM_MODE_RUN: begin
        // Fast runs while it clocks the CPU; else per its enable bit
        fast_on = ~active_sub_q |
                  (fast_source_select_q ? fxt_en_q : frc_en_q);
        sub_on  = 1'b1;
        sys_on  = 1'b1;
      end
      `SCM_MODE_IDLE_SLOW_ONLY: begin
        fast_on = 1'b0;
        sub_on  = 1'b1;
        sys_on  = active_sub_q;
      end
      `SCM_MODE_IDLE_BOTH_OSC: begin
        fast_on = 1'b1;
        sub_on  = 1'b1;
        sys_on  = 1'b1;
      end
      `SCM_MODE_IDLE_FAST_ONLY: begin
        fast_on = 1'b1;
        sub_on  = 1'b0;
        sys_on  = ~active_sub_q;
      end
      default: begin
        fast_on = 1'b0;
        sub_on  = 1'b0;
        sys_on  = 1'b0;
      end
    endcase
  end

  // Oscillator run controls
  assign fast_rc_osc_run      = fast_on & ~fast_source_select_q |
                                running & frc_en_q;
  assign fast_crystal_osc_run = fast_on & fast_source_select_q |
                                running & fxt_en_q;
  assign slow_crystal_osc_run = sub_on & slow_source_select_q |
                                running & sxt_en_q;
  // Slow RC stays up outside sleep; in sleep only for the watchdog
  assign slow_rc_osc_run      = (mode_q != `SCM_MODE_SLEEP) |
                                watchdog_function_en;

  assign fast_rc_freq          = frc_freq_q;
  assign fast_crystal_mode     = fxt_mode_q;
  assign slow_crystal_speed_up = sxt_speed_q;
  assign cpu_run               = running;

  wire fast_raw = fast_source_select_q ? fast_crystal_tick : fast_rc_tick;
  wire sub_raw  = slow_source_select_q ? slow_crystal_tick : slow_rc_tick;
  assign fast_clk_tick      = ce & fast_on & fast_raw;
  assign sub_clk_tick       = ce & sub_on & sub_raw;
  assign slow_rc_clock_tick = ce & slow_rc_osc_run & slow_rc_tick;

  // Divided fast tick: divider 2^n fires when low n counter bits are all ones
  reg [5:0] div_mask;
  always @* begin
    case (div_active_q)
      3'h0:    div_mask = 6'h00;
      3'h1:    div_mask = 6'h01;
      3'h2:    div_mask = 6'h03;
      3'h3:    div_mask = 6'h07;
      3'h4:    div_mask = 6'h0f;
      3'h5:    div_mask = 6'h1f;
      default: div_mask = 6'h3f;
    endcase
  end
  wire div_fire = fast_clk_tick & ((div_cnt_q & div_mask) == div_mask);
  // Every ratio ends a period at the counter wrap, so changes land there
  wire div_wrap = fast_clk_tick & (div_cnt_q == `SCM_DIV_WRAP);

  // Clock path: ratio and source only change on a period boundary
  always @(posedge clk) begin
    if (sys_rst) begin
      div_cnt_q    <= 6'h00;
      div_active_q <= 3'h0;
      active_sub_q <= 1'b0;
      sys_clk_tick <= 1'b0;
    end else if (ce) begin
      sys_clk_tick <= sys_on & (active_sub_q ? sub_clk_tick : div_fire);
      if (fast_clk_tick)
        div_cnt_q <= div_cnt_q + 6'h01;
      if (!active_sub_q) begin
        if (div_wrap) begin
          // Hold the fast path until the chosen slow source is stable
          if (want_sub && sub_ready)
            active_sub_q <= 1'b1;
          else if (!want_sub)
            div_active_q <= sys_clk_selector_q;
        end
      end else if (!want_sub && fast_rdy && sub_clk_tick) begin
        // Leave the sub clock right after one of its ticks, counter restarted
        active_sub_q <= 1'b0;
        div_active_q <= sys_clk_selector_q;
        div_cnt_q    <= 6'h00;
      end
    end
  end

  // Mode sequencing
  always @(posedge clk) begin
    if (sys_rst) begin
      mode_q         <= `SCM_MODE_RUN;
      watchdog_clear <= 1'b0;
    end else if (ce) begin
      watchdog_clear <= 1'b0;
      case (mode_q)
        `SCM_MODE_RUN: begin
          if (halt_req) begin
            case ({fast_keep_alive_q, slow_keep_alive_q})
              2'b00: begin
                mode_q         <= `SCM_MODE_SLEEP;
                watchdog_clear <= 1'b1;
              end
              2'b01:   mode_q <= `SCM_MODE_IDLE_SLOW_ONLY;
              2'b11:   mode_q <= `SCM_MODE_IDLE_BOTH_OSC;
              default: mode_q <= `SCM_MODE_IDLE_FAST_ONLY;
            endcase
          end
        end
        `SCM_MODE_SLEEP,
        `SCM_MODE_IDLE_SLOW_ONLY,
        `SCM_MODE_IDLE_BOTH_OSC,
        `SCM_MODE_IDLE_FAST_ONLY: begin
          if (wake_req)
            mode_q <= `SCM_MODE_RUN;
        end
        default: mode_q <= `SCM_MODE_RUN;
      endcase
    end
  end

  // Register writes
  always @(posedge clk) begin
    if (sys_rst) begin
      sys_clk_selector_q   <= `SCM_SEL_RST;
      fast_source_select_q <= 1'b0;
      slow_source_select_q <= 1'b0;
      fast_keep_alive_q    <= 1'b0;
      slow_keep_alive_q    <= 1'b0;
      // Fast RC comes up enabled so a system clock exists from power-on
      {frc_freq_q, frc_en_q} <= `SCM_FRC_RST;
      fxt_mode_q           <= 1'b0;
      fxt_en_q             <= 1'b0;
      sxt_speed_q          <= 1'b0;
      sxt_en_q             <= 1'b0;
    end else if (wr) begin
      if (hit_sys) begin
        sys_clk_selector_q   <= pwdata[`SCM_SEL_MSB:`SCM_SEL_LSB];
        fast_source_select_q <= pwdata[`SCM_FSRC_BIT];
        slow_source_select_q <= pwdata[`SCM_SSRC_BIT];
        fast_keep_alive_q    <= pwdata[`SCM_FKEEP_BIT];
        slow_keep_alive_q    <= pwdata[`SCM_SKEEP_BIT];
      end
      if (hit_frc) begin
        frc_freq_q <= pwdata[`SCM_FRC_FREQ_MSB:`SCM_FRC_FREQ_LSB];
        frc_en_q   <= pwdata[`SCM_OSC_EN_BIT];
      end
      if (hit_fxt) begin
        // Mode is locked while the crystal is enabled
        if (!fxt_en_q)
          fxt_mode_q <= pwdata[`SCM_OSC_MODE_BIT];
        fxt_en_q <= pwdata[`SCM_OSC_EN_BIT];
      end
      if (hit_sxt) begin
        // Speed-up is locked once the crystal clocks the system
        if (!(active_sub_q && slow_source_select_q))
          sxt_speed_q <= pwdata[`SCM_OSC_MODE_BIT];
        sxt_en_q <= pwdata[`SCM_OSC_EN_BIT];
      end
    end
  end

  // Read mux; bit 4 of the control word is always zero
  always @* begin
    prdata = 32'h0000_0000;
    if (acc && !pwrite) begin
      if (hit_sys)
        prdata[7:0] = {sys_clk_selector_q, 1'b0, fast_source_select_q,
                       slow_source_select_q, fast_keep_alive_q,
                       slow_keep_alive_q};
      if (hit_frc)
        prdata[3:0] = {frc_freq_q, fast_rc_stable, frc_en_q};
      if (hit_fxt)
        prdata[2:0] = {fxt_mode_q, fast_crystal_stable, fxt_en_q};
      if (hit_sxt)
        prdata[2:0] = {sxt_speed_q, slow_crystal_stable, sxt_en_q};
      if (hit_sts)
        prdata[6:0] = {div_active_q, active_sub_q, mode_q};
    end
  end

endmodule

// *** testbench/scm_clock_mode_assertions.sv ***
// Purpose: Port-level checks for scm_clock_mode
// Assumes: Sleep is the halt mode that pulses watchdog_clear
// Notes:   Sleep is tracked from that pulse until cpu_run returns
`timescale 1ns/1ps
module scm_clock_mode_assertions (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // CPU side
  input wire ce,
  input wire halt_req,
  input wire wake_req,
  input wire watchdog_function_en,
  input wire cpu_run,
  input wire watchdog_clear,
  // Clocks
  input wire slow_rc_tick,
  input wire slow_rc_osc_run,
  input wire sys_clk_tick,
  input wire fast_clk_tick,
  input wire sub_clk_tick,
  input wire slow_rc_clock_tick
);
  reg sleep_q;
  // Set one cycle late so the last registered system tick may still leave
  always @(posedge clk)
    sleep_q <= sys_rst ? 1'b0 : watchdog_clear ? 1'b1 : cpu_run ? 1'b0 : sleep_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence halt_taken;
    cpu_run && halt_req && ce && !wake_req;
  endsequence
  sequence in_sleep;
    sleep_q && !cpu_run;
  endsequence

  halt_stops_cpu_a: assert property (halt_taken |=> !cpu_run)
    else $error("cpu kept running after halt");
  sleep_entry_a: assert property (watchdog_clear |-> !cpu_run ##1 !watchdog_clear)
    else $error("watchdog clear not a single pulse at sleep entry");
  sleep_clocks_off_a: assert property (in_sleep |-> !fast_clk_tick && !sub_clk_tick && !sys_clk_tick)
    else $error("clock tick while asleep");
  sleep_rc_wd_a: assert property (in_sleep |-> slow_rc_osc_run == watchdog_function_en)
    else $error("slow rc run does not follow watchdog enable in sleep");
  rc_off_cause_a: assert property (!slow_rc_osc_run |-> !cpu_run && !watchdog_function_en)
    else $error("slow rc stopped outside sleep without watchdog");
  run_rc_tick_a: assert property (cpu_run && ce |-> slow_rc_clock_tick == slow_rc_tick)
    else $error("slow rc clock not passed while running");
  idle_rc_runs_a: assert property (!cpu_run && !watchdog_clear && !sleep_q |-> slow_rc_osc_run)
    else $error("slow rc stopped in idle");
  reset_run_a: assert property ($fell(sys_rst) |-> cpu_run && !watchdog_clear)
    else $error("not running after reset");
endmodule

bind scm_clock_mode scm_clock_mode_assertions scm_clock_mode_assertions_inst (.clk, .sys_rst,
  .ce, .halt_req, .wake_req, .watchdog_function_en, .cpu_run, .watchdog_clear, .slow_rc_tick,
  .slow_rc_osc_run, .sys_clk_tick, .fast_clk_tick, .sub_clk_tick, .slow_rc_clock_tick);

// *** testbench/scm_clock_mode_test.sv ***
// Purpose: Self-checking bench for scm_clock_mode
// Assumes: Fast stable flags high; oscillator ticks random
// Notes:   Clock activity is judged over windows of cycles
`timescale 1ns/1ps
`include "scm_defs.vh"
module scm_clock_mode_test;
  reg         clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg         halt_req = 1'b0;
  reg         wake_req = 1'b0;
  reg         watchdog_function_en = 1'b0;
  reg         slow_crystal_stable = 1'b1;
  reg  [3:0]  tk = 4'h0;
  reg  [2:0]  n_cur = 3'h0;
  reg         s_cur = 1'b0;
  reg         tdly = 1'b0;
  reg  [31:0] rd;
  reg         err;
  wire        pready, pslverr, cpu_run, watchdog_clear;
  wire        sys_clk_tick, fast_clk_tick, sub_clk_tick, slow_rc_clock_tick;
  wire [31:0] prdata;
  wire        fast_rc_osc_run, fast_crystal_osc_run, slow_crystal_osc_run;
  wire [1:0]  fast_rc_freq;
  wire        fast_crystal_mode, slow_crystal_speed_up;
  integer     err_total = 0;
  integer     checked = 0;
  integer     seed = 32'h91da;
  integer     cyc = 0;
  integer     tc = 0, sc = 0, fc = 0, uc = 0, rc = 0, wc = 0;
  integer     i, t0, s0, f0, u0, r0, w0;

  scm_clock_mode scm_clock_mode_inst (.clk, .sys_rst, .ce(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .prdata, .halt_req, .wake_req, .watchdog_function_en,
    .cpu_run, .watchdog_clear, .fast_rc_tick(tk[0]), .fast_crystal_tick(tk[1]),
    .slow_rc_tick(tk[2]), .slow_crystal_tick(tk[3]), .fast_rc_stable(1'b1),
    .fast_crystal_stable(1'b1), .slow_crystal_stable, .fast_rc_osc_run,
    .fast_crystal_osc_run, .slow_rc_osc_run(), .slow_crystal_osc_run, .fast_rc_freq,
    .fast_crystal_mode, .slow_crystal_speed_up, .sys_clk_tick, .fast_clk_tick,
    .sub_clk_tick, .slow_rc_clock_tick);

  always #10 clk = ~clk;

  // tdly is the selected source tick, aligned with sys_clk_tick
  always @(posedge clk) begin
    tk <= $random(seed);
    cyc <= cyc + 1;
    tdly <= tk[{n_cur == 3'h7, s_cur}];
    tc <= tc + tdly;
    sc <= sc + sys_clk_tick;
    fc <= fc + fast_clk_tick;
    uc <= uc + sub_clk_tick;
    rc <= rc + slow_rc_clock_tick;
    wc <= wc + watchdog_clear;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      tally_and_finish;
    end
  end

  function integer exp_ratio(input reg [2:0] n, input integer t);
    exp_ratio = (n == 3'h7) ? t : t >> n;
  endfunction

  // {fast, sub, system, slow rc, watchdog clear} activity while halted
  function [4:0] exp_act(input reg [2:0] c, input reg w);
    exp_act = {c[1], c[0], c[2] ? c[0] : c[1], c[1:0] == 2'b00 ? w : 1'b1, c[1:0] == 2'b00};
  endfunction

  task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the global cycle ceiling ends a hung slave
      do
        @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task cmp(input reg [95:0] nm, input reg [31:0] e, input reg [31:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("mismatch %0s exp %h got %h", nm, e, g);
      end
    end
  endtask

  task wait_mode(input reg [2:0] n);
    begin
      do
        apb(1'b0, `SCM_OFF_STATUS, 32'h0);
      while (n == 3'h7 ? rd[3] !== 1'b1 : rd[6:3] !== {n, 1'b0});
    end
  endtask

  task tally_and_finish;
    begin
      if (err_total == 0 && checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, `SCM_OFF_SYS_CTRL, 32'h0);
    cmp("ctrl reset", {24'h0, `SCM_SYS_CTRL_RST}, rd);
    // Oscillator fields before any crystal clocks the system
    apb(1'b1, `SCM_OFF_FRC_CTRL, 32'hd);
    apb(1'b1, `SCM_OFF_FXT_CTRL, 32'h5);
    apb(1'b1, `SCM_OFF_SXT_CTRL, 32'h5);
    @(negedge clk);
    cmp("osc fields", 32'hf, {28'h0, fast_rc_freq, fast_crystal_mode, slow_crystal_speed_up});
    for (i = 0; i < 6; i = i + 1) begin
      t0 = $random(seed);
      apb(1'b1, `SCM_OFF_SYS_CTRL, t0);
      apb(1'b0, `SCM_OFF_SYS_CTRL, 32'h0);
      cmp("ctrl rw", t0 & 32'hef, rd);
    end
    apb(1'b0, 12'h020, 32'h0);
    cmp("unmapped", 32'h1, {31'h0, err});
    // Every selector code, with both fast and both slow origins
    for (i = 0; i < 16; i = i + 1) begin
      if (i == 15) begin
        @(posedge clk);
        slow_crystal_stable <= 1'b0;
      end
      apb(1'b1, `SCM_OFF_SYS_CTRL, {24'h0, i[2:0], 1'b0, i[3], i[3], 2'b00});
      if (i == 15) begin
        repeat (80) @(posedge clk);
        apb(1'b0, `SCM_OFF_STATUS, 32'h0);
        cmp("sub early", 32'h0, {31'h0, rd[3]});
        slow_crystal_stable <= 1'b1;
      end
      wait_mode(i[2:0]);
      n_cur <= i[2:0];
      s_cur <= i[3];
      repeat (2) @(negedge clk);
      t0 = tc;
      s0 = sc;
      while (tc - t0 < 128)
        @(negedge clk);
      cmp("ratio", exp_ratio(i[2:0], 128), sc - s0);
    end
    // Slow mode on the slow crystal: fast crystal follows its own enable bit
    for (i = 0; i < 2; i = i + 1) begin
      apb(1'b1, `SCM_OFF_FXT_CTRL, {31'h0, i[0]});
      repeat (2) @(negedge clk);
      f0 = fc;
      repeat (60) @(negedge clk);
      cmp("fast in slow", {28'h0, i[0], 1'b1, i[0], 1'b1},
          {28'h0, fc != f0, fast_rc_osc_run, fast_crystal_osc_run,
           slow_crystal_osc_run});
      @(posedge clk);
    end
    // Each halt mode from fast and from slow running
    for (i = 0; i < 8; i = i + 1) begin
      watchdog_function_en <= $random(seed);
      apb(1'b1, `SCM_OFF_SYS_CTRL, {24'h0, {3{i[2]}}, 3'h0, i[1:0]});
      wait_mode({3{i[2]}});
      w0 = wc;
      @(posedge clk);
      halt_req <= 1'b1;
      @(posedge clk);
      halt_req <= 1'b0;
      repeat (2) @(negedge clk);
      f0 = fc;
      u0 = uc;
      s0 = sc;
      r0 = rc;
      repeat (60) @(negedge clk);
      cmp("halt act", exp_act(i[2:0], watchdog_function_en),
          {fc != f0, uc != u0, sc != s0, rc != r0, wc != w0});
      @(posedge clk);
      wake_req <= 1'b1;
      @(posedge clk);
      wake_req <= 1'b0;
    end
    tally_and_finish;
  end
endmodule
